// >>> fzv_consts.vh
// constants for the flame zone voting controller
// assumes a 10 MHz aclk and a 32-bit AXI4-Lite register port
`ifndef FZV_CONSTS_VH
`define FZV_CONSTS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define FZV_ADDR_CFG 4'h0
`define FZV_ADDR_STAT 4'h4
`define FZV_ADDR_WDOG 4'h8
`define FZV_CFG_RESET 32'h0000_0108
`define FZV_CFG_DET 3:0
`define FZV_CFG_LATCH 4
`define FZV_CFG_COMMON 5
`define FZV_CFG_VA2 6
`define FZV_CFG_VB2 7
`define FZV_CFG_VCOM 10:8
`define FZV_CFG_CHAIN 11
`define FZV_CFG_MASTER 12
`define FZV_CFG_WDEN 13
`define FZV_RESP_OK 2'h0
`define FZV_RESP_ERR 2'h2
// ----------------------------------------
// display codes and bus count limit
// ----------------------------------------
`define FZV_ST_BLANK 4'hF
`define FZV_ZN_BLANK 8'hFF
`define FZV_BUS_MAX 7'h40
// ----------------------------------------
// timing
// ----------------------------------------
`define FZV_CLK_KHZ 10000
`define FZV_BLINK_MS 500
`define FZV_WDOG_MS 1000
`define FZV_RATE_MS 1000
`endif

// >>> fzv_sync.v
// two-stage synchroniser for a bundle of pins
// assumes each bit is an independent level
`timescale 1ns/100ps
module fzv_sync #(
   parameter W = 8,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire aclk,
   input wire aresetn,
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);
   reg [W-1:0] meta;
   // ----------------------------------------
   // first stage feeds only the second
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         // reset to each pin's idle level, so no false event follows reset
         meta <= INIT;
         dout <= INIT;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // fzv_sync

// >>> fzv_top.v
// flame zone voting controller core with AXI4-Lite registers
// assumes qualified fire levels per zone from detector logic
`timescale 1ns/100ps
`include "fzv_consts.vh"
module fzv_top #(
   parameter BLINK_HALF = `FZV_BLINK_MS * `FZV_CLK_KHZ,
   parameter WDOG_CYC = `FZV_WDOG_MS * `FZV_CLK_KHZ,
   parameter RATE_CYC = `FZV_RATE_MS * `FZV_CLK_KHZ
) (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [7:0] fire_in,
   input wire [7:0] response_in,
   input wire [7:0] optical_selftest,
   input wire supply_low,
   input wire supply_high,
   input wire key_reset,
   input wire key_test,
   input wire remote_inhibit_n,
   input wire remote_accept_n,
   input wire select_button,
   input wire accept_button,
   input wire lamp_check_button,
   input wire [7:0] bus_in,
   output reg [7:0] bus_out,
   output reg [7:0] zone_out,
   output reg [7:0] zone_indicator,
   output reg logic_a,
   output reg logic_b,
   output reg alarm_out,
   output reg fault_out,
   output reg fault_indicator,
   output reg inhibit_out,
   output reg [3:0] status_code,
   output reg [7:0] zone_disp
);
   // ----------------------------------------
   // input synchronisation
   // ----------------------------------------
   wire [40:0] pins_s;
   fzv_sync #(.W(41), .INIT(41'h00030000000)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({bus_in, lamp_check_button, accept_button, select_button,
            remote_accept_n, remote_inhibit_n, key_test, key_reset,
            supply_high, supply_low, optical_selftest, response_in, fire_in}),
      .dout(pins_s)
   );
   wire [7:0] fire_s = pins_s[7:0], resp_s = pins_s[15:8], oit_s = pins_s[23:16];
   wire low_s = pins_s[24], high_s = pins_s[25], krst_s = pins_s[26], ktst_s = pins_s[27], lamp_s = pins_s[32];
   wire rinh_s = ~pins_s[28], racc_s = ~pins_s[29], sel_s = pins_s[30], acc_s = pins_s[31];
   wire [7:0] bus_s = pins_s[40:33];
   // ----------------------------------------
   // configuration and supervision state
   // ----------------------------------------
   reg [31:0] cfg;
   reg [23:0] wd_cnt, blink_cnt, win_cnt;
   reg [7:0] rate_cnt, rate, zone_hold, seen;
   reg [3:0] first_zone;
   reg [2:0] sel_zone;
   reg proc_fail, blink, ack, combo, count_mode, sel_d, acc_d, mon_d;
   wire [3:0] det_n = cfg[`FZV_CFG_DET];
   wire inh_key = krst_s | ktst_s;
   wire rst_ev = krst_s | rinh_s;
   wire inhibit = inh_key | rinh_s;
   // unused zones drop out of votes and fault checks
   wire [7:0] used;
   wire [7:0] fire_q = fire_s & used;
   wire [7:0] resp_q = resp_s & used & ~fire_s;
   wire [7:0] oit_q = oit_s & used;
   function [3:0] popc;
      input [7:0] v;
      integer k;
      begin
         popc = 4'h0;
         for (k = 0; k < 8; k = k + 1)
            popc = popc + {3'h0, v[k]};
      end
   endfunction
   function [3:0] lowest;
      input [7:0] v;
      integer k;
      begin
         lowest = 4'h0;
         for (k = 7; k >= 0; k = k - 1)
            if (v[k]) lowest = k[3:0] + 4'h1;
      end
   endfunction
   // ----------------------------------------
   // per-zone outputs and indicators
   // ----------------------------------------
   wire [7:0] next_hold, next_ind;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_zone
         assign used[g] = (det_n > g);
         // latching keeps the zone until reset
         assign next_hold[g] = rst_ev ? fire_q[g] :
            (cfg[`FZV_CFG_LATCH] ? (zone_hold[g] | fire_q[g]) : fire_q[g]);
         // blink while responding, steady once quiet
         assign next_ind[g] = lamp_s | (fire_q[g] ? blink :
            (seen[g] ? 1'b1 : (resp_q[g] & blink)));
      end
   endgenerate

   // ----------------------------------------
   // voting
   // ----------------------------------------
   wire [3:0] cnt_a = popc({4'h0, zone_hold[3:0]});
   wire [3:0] cnt_b = popc({4'h0, zone_hold[7:4]});
   wire [3:0] cnt_all = popc(zone_hold);
   wire from_up = cfg[`FZV_CFG_CHAIN] & ~cfg[`FZV_CFG_MASTER];
   // upstream word is a 7-bit zone count with even parity on top
   wire [6:0] up_cnt = from_up ? bus_s[6:0] : 7'h00;
   wire [6:0] total = up_cnt + {3'h0, cnt_all};
   wire [2:0] vcom = cfg[`FZV_CFG_VCOM];
   wire [2:0] vmin = (vcom == 3'h0) ? 3'h1 : vcom;
   wire [3:0] min_a = cfg[`FZV_CFG_VA2] ? 4'h2 : 4'h1;
   wire [3:0] min_b = cfg[`FZV_CFG_VB2] ? 4'h2 : 4'h1;
   wire vote_a = ~cfg[`FZV_CFG_COMMON] & (cnt_a >= min_a);
   wire vote_b = cfg[`FZV_CFG_COMMON] ? (total >= {4'h0, vmin}) : (cnt_b >= min_b);
   // parity and range check stand in for the bus wiring test
   wire bus_fault = from_up & ((^bus_s) | (bus_s[6:0] > `FZV_BUS_MAX));

   // ----------------------------------------
   // fault and status selection
   // ----------------------------------------
   wire any_fault = (|oit_q) | low_s | high_s | bus_fault | proc_fail;
   wire any_fire = |zone_hold;
   reg [3:0] next_st;
   reg [7:0] next_zn;
   always @* begin
      next_st = `FZV_ST_BLANK;
      next_zn = `FZV_ZN_BLANK;
      if (proc_fail) begin
         next_st = `FZV_ST_BLANK;
      end else if (rst_ev) begin
         next_st = 4'h0;
         next_zn = 8'h00;
      end else if (ktst_s & count_mode) begin
         next_st = 4'h8;
         next_zn = rate;
      end else if (ktst_s) begin
         next_st = 4'h1;
         next_zn = {5'h00, sel_zone} + 8'h01;
      end else if (first_zone != 4'h0) begin
         next_st = 4'h6;
         next_zn = {4'h0, first_zone};
      end else if (|oit_q) begin
         next_st = 4'h2;
         next_zn = {4'h0, lowest(oit_q)};
      end else if (low_s) begin
         next_st = 4'h4;
      end else if (high_s) begin
         next_st = 4'h5;
      end else if (bus_fault) begin
         next_st = 4'h7;
      end else if (|resp_q) begin
         next_st = 4'h3;
      end
   end

   // ----------------------------------------
   // zone, alarm and panel state
   // ----------------------------------------
   wire sel_rise = sel_s & ~sel_d;
   wire acc_rise = acc_s & ~acc_d;
   wire mon = fire_q[sel_zone] | resp_s[sel_zone];
   wire [2:0] sel_last = det_n[2:0] - 3'h1;
   always @(posedge aclk) begin
      if (!aresetn) begin
         zone_hold <= 8'h00;
         seen <= 8'h00;
         first_zone <= 4'h0;
         ack <= 1'b0;
         sel_zone <= 3'h0;
         combo <= 1'b0;
         count_mode <= 1'b0;
         sel_d <= 1'b0;
         acc_d <= 1'b0;
         mon_d <= 1'b0;
         blink_cnt <= 24'h000000;
         blink <= 1'b0;
         win_cnt <= 24'h000000;
         rate_cnt <= 8'h00;
         rate <= 8'h00;
      end else begin
         sel_d <= sel_s;
         acc_d <= acc_s;
         mon_d <= mon;
         zone_hold <= next_hold;
         seen <= rst_ev ? 8'h00 : ((seen | zone_hold) & ~fire_q);
         if (rst_ev)
            first_zone <= 4'h0;
         else if ((first_zone == 4'h0) && (|fire_q))
            first_zone <= lowest(fire_q);
         // accept wins over a reset in the same cycle
         if (any_fire & ~ktst_s & (racc_s | acc_rise))
            ack <= 1'b1;
         else if (rst_ev | ~any_fire)
            ack <= 1'b0;
         if (!ktst_s) begin
            combo <= 1'b0;
            count_mode <= 1'b0;
         end else if (sel_s & acc_s) begin
            combo <= 1'b1;
         end else if (combo & ~sel_s & ~acc_s) begin
            combo <= 1'b0;
            count_mode <= 1'b1;
         end else if (sel_rise & ~acc_s & ~combo) begin
            sel_zone <= (sel_zone >= sel_last) ? 3'h0 : sel_zone + 3'h1;
         end
         blink_cnt <= (blink_cnt >= BLINK_HALF - 1) ? 24'h000000 : blink_cnt + 24'h000001;
         if (blink_cnt >= BLINK_HALF - 1)
            blink <= ~blink;
         // rate saturates rather than wrap in a busy zone
         if (win_cnt >= RATE_CYC - 1) begin
            win_cnt <= 24'h000000;
            rate <= rate_cnt;
            rate_cnt <= 8'h00;
         end else begin
            win_cnt <= win_cnt + 24'h000001;
            if (mon & ~mon_d & (rate_cnt != 8'hFF))
               rate_cnt <= rate_cnt + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         zone_out <= 8'h00;
         zone_indicator <= 8'h00;
         logic_a <= 1'b0;
         logic_b <= 1'b0;
         alarm_out <= 1'b0;
         fault_out <= 1'b0;
         fault_indicator <= 1'b0;
         inhibit_out <= 1'b0;
         status_code <= `FZV_ST_BLANK;
         zone_disp <= `FZV_ZN_BLANK;
         bus_out <= 8'h00;
      end else begin
         zone_out <= inhibit ? 8'h00 : zone_hold;
         zone_indicator <= next_ind;
         logic_a <= vote_a & ~inhibit;
         logic_b <= vote_b & ~inhibit;
         alarm_out <= any_fire & ~ack & ~inhibit;
         fault_out <= ~any_fault;
         fault_indicator <= any_fault | inh_key | lamp_s;
         inhibit_out <= inhibit;
         status_code <= lamp_s ? 4'h8 : next_st;
         zone_disp <= lamp_s ? 8'h88 : next_zn;
         // alarm and fault states never ride the bus
         bus_out <= {^total, total};
      end
   end
   // ----------------------------------------
   // supervisory timer
   // ----------------------------------------
   wire wd_kick;
   always @(posedge aclk) begin
      if (!aresetn) begin
         wd_cnt <= 24'h000000;
         proc_fail <= 1'b0;
      end else if ((krst_s & lamp_s) | wd_kick | ~cfg[`FZV_CFG_WDEN]) begin
         wd_cnt <= 24'h000000;
         proc_fail <= (proc_fail & ~(krst_s & lamp_s)) | (cfg[`FZV_CFG_WDEN] & ~wd_kick & (wd_cnt >= WDOG_CYC - 1));
      end else if (wd_cnt >= WDOG_CYC - 1) begin
         proc_fail <= 1'b1;
      end else begin
         wd_cnt <= wd_cnt + 24'h000001;
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   reg aw_full, w_full;
   reg [3:0] aw_addr, w_strb;
   reg [31:0] w_data;
   wire do_wr = aw_full & w_full & ~s_axi_bvalid;
   assign wd_kick = do_wr & (aw_addr == `FZV_ADDR_WDOG);
   integer b;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FZV_RESP_OK;
         cfg <= `FZV_CFG_RESET;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= ((aw_addr == `FZV_ADDR_CFG) || (aw_addr == `FZV_ADDR_WDOG)) ? `FZV_RESP_OK : `FZV_RESP_ERR;
            if (aw_addr == `FZV_ADDR_CFG)
               for (b = 0; b < 4; b = b + 1)
                  if (w_strb[b]) cfg[b*8 +: 8] <= w_data[b*8 +: 8];
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `FZV_RESP_OK;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `FZV_RESP_OK;
         if (s_axi_araddr == `FZV_ADDR_CFG) begin
            s_axi_rdata <= cfg;
         end else if (s_axi_araddr == `FZV_ADDR_STAT) begin
            s_axi_rdata <= {6'h00, proc_fail, inhibit_out, alarm_out, logic_b, logic_a,
                            zone_out, fault_out, zone_disp, status_code};
         end else if (s_axi_araddr == `FZV_ADDR_WDOG) begin
            s_axi_rdata <= {8'h00, wd_cnt};
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FZV_RESP_ERR;
         end
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // fzv_top

// >>> fzv_top_props.sv
// port checker for the flame zone voting controller
// assumes pins are held several cycles before outputs are judged
`timescale 1ns/100ps
module fzv_top_props (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] fire_in,
   input wire [7:0] optical_selftest,
   input wire key_reset,
   input wire key_test,
   input wire remote_inhibit_n,
   input wire remote_accept_n,
   input wire accept_button,
   input wire lamp_check_button,
   input wire [7:0] bus_out,
   input wire [7:0] zone_out,
   input wire logic_a,
   input wire logic_b,
   input wire alarm_out,
   input wire fault_out,
   input wire fault_indicator,
   input wire inhibit_out,
   input wire [3:0] status_code
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   // six samples cover the pin lag of up to four edges with margin
   property p_key_reset;
      (key_reset && !lamp_check_button) [*6] |-> status_code == 4'h0 && zone_out == 8'h00 && !alarm_out;
   endproperty
   a_key_reset: assert property (p_key_reset) else $error("outputs live in key reset");
   property p_test_mode;
      (key_test && !key_reset) [*6] |-> inhibit_out && zone_out == 8'h00 && (status_code == 4'h1 || status_code == 4'h8);
   endproperty
   a_test_mode: assert property (p_test_mode) else $error("test mode not inhibited");
   property p_remote_inh;
      (!remote_inhibit_n) [*6] |-> inhibit_out && !logic_a && !logic_b;
   endproperty
   a_remote_inh: assert property (p_remote_inh) else $error("remote inhibit ignored");
   property p_selftest;
      optical_selftest[0] [*6] |-> !fault_out && fault_indicator;
   endproperty
   a_selftest: assert property (p_selftest) else $error("self-test fault not flagged");
   property p_zone_fire;
      (fire_in[0] && remote_inhibit_n && !key_reset && !key_test) [*6] |-> zone_out[0];
   endproperty
   a_zone_fire: assert property (p_zone_fire) else $error("zone output missing");
   property p_alarm;
      $rose(zone_out[0]) && remote_accept_n && !accept_button |-> ##[0:2] alarm_out;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm late");
   property p_accept;
      (!remote_accept_n) [*6] |-> !alarm_out;
   endproperty
   a_accept: assert property (p_accept) else $error("alarm kept after accept");
   property p_vote_a;
      logic_a |-> zone_out[3:0] != 4'h0 || $past(zone_out[3:0]) != 4'h0;
   endproperty
   a_vote_a: assert property (p_vote_a) else $error("group A without zone");
   property p_bus_word;
      (^bus_out) == 1'b0 && bus_out[6:0] <= 7'h40;
   endproperty
   a_bus_word: assert property (p_bus_word) else $error("bad vote word");
   property p_status_code;
      status_code <= 4'h8 || status_code == 4'hF;
   endproperty
   a_status_code: assert property (p_status_code) else $error("bad status code");
   c_alarm: cover property (alarm_out);
   c_bus_fault: cover property (status_code == 4'h7);
   c_logic_b: cover property (logic_b && !zone_out[7]);
endmodule // fzv_top_props

bind fzv_top fzv_top_props i_props (.*);

// >>> fzv_upstream.sv
// upstream controller model driving the chained vote bus
// assumes the bench sets the count it forwards
`timescale 1ns/100ps
module fzv_upstream (
   input wire aclk,
   input wire [6:0] up_count,
   input wire corrupt,
   output reg [7:0] bus_in
);
   // ----------------------------------------
   // vote word
   // ----------------------------------------
   // only the vote count travels, fault and alarm stay local
   initial bus_in = 8'h00;
   always @(posedge aclk) begin
      // one-way word, even parity; corrupt flips it on command
      bus_in <= {(^up_count) ^ corrupt, up_count};
   end
endmodule // fzv_upstream

// >>> tb_fzv_top.sv
// bench for the flame zone voting controller
// assumes shortened blink, watchdog and rate parameters
`timescale 1ns/100ps
module tb_fzv_top;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [3:0] s_axi_awaddr = 4'h0;
   reg s_axi_awvalid = 1'b0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg [3:0] s_axi_araddr = 4'h0;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   reg [7:0] fire_in = 8'h00, response_in = 8'h00, optical_selftest = 8'h00;
   reg supply_low = 1'b0, supply_high = 1'b0, key_reset = 1'b0, key_test = 1'b0;
   reg remote_inhibit_n = 1'b1, remote_accept_n = 1'b1;
   reg select_button = 1'b0, accept_button = 1'b0, lamp_check_button = 1'b0;
   wire [7:0] bus_in, bus_out, zone_out, zone_indicator, zone_disp;
   wire logic_a, logic_b, alarm_out, fault_out, fault_indicator, inhibit_out;
   wire [3:0] status_code;
   reg [6:0] up_count = 7'h00;
   reg corrupt = 1'b0;
   reg hi = 1'b0;
   reg lo = 1'b0;
   integer failures = 0;
   integer compares = 0;
   always #50 aclk = ~aclk;
   fzv_top #(.BLINK_HALF(8), .WDOG_CYC(64), .RATE_CYC(32)) i_dut (.*);
   fzv_upstream i_up (.*);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wt(input integer n);
      begin
         repeat (n) @(posedge aclk);
      end
   endtask
   task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
      integer n;
      reg done;
      begin
         s_axi_awaddr <= a;
         s_axi_awvalid <= 1'b1;
         s_axi_wdata <= d;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         done = 1'b0;
         n = 0;
         while (!done && n < 50) begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
               done = 1'b1;
               chk(s_axi_bresp, er);
            end
         end
         if (!done) failures = failures + 1;
      end
   endtask
   task axi_rd(input [3:0] a, input [31:0] ed, input [1:0] er);
      integer n;
      reg done;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         done = 1'b0;
         n = 0;
         while (!done && n < 50) begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) begin
               done = 1'b1;
               chk(s_axi_rdata, ed);
               chk(s_axi_rresp, er);
            end
         end
         if (!done) failures = failures + 1;
      end
   endtask
   // voting cases restore no-fire afterwards so the next case starts clean
   task vote(input [31:0] cfg, input [7:0] f, input [1:0] m, input [1:0] e);
      begin
         axi_wr(4'h0, cfg, 2'h0);
         fire_in <= f;
         wt(6);
         chk({logic_a, logic_b} & m, e);
         fire_in <= 8'h00;
         wt(6);
      end
   endtask
   task clr;
      begin
         key_reset <= 1'b1;
         wt(6);
         key_reset <= 1'b0;
         wt(6);
      end
   endtask
   task tally_and_finish;
      begin
         if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
         end else begin
            $display("Finished with errors");
         end
         $finish;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      #1000000;
      failures = failures + 1;
      tally_and_finish;
   end
   initial begin
      wt(5);
      aresetn <= 1'b1;
      wt(4);
      axi_rd(4'h0, 32'h108, 2'h0);
      axi_rd(4'h4, 32'h1FFF, 2'h0);
      axi_wr(4'h4, 32'h0, 2'h2);
      axi_wr(4'hC, 32'h0, 2'h2);
      axi_rd(4'hC, 32'h0, 2'h2);
      optical_selftest <= 8'h01;
      wt(6);
      chk(status_code, 4'h2);
      chk(zone_disp, 8'h01);
      chk({fault_out, fault_indicator}, 2'b01);
      optical_selftest <= 8'h04;
      axi_wr(4'h0, 32'h102, 2'h0);
      wt(6);
      chk(fault_out, 1'b1);
      optical_selftest <= 8'h00;
      axi_wr(4'h0, 32'h108, 2'h0);
      supply_low <= 1'b1;
      wt(6);
      chk({status_code, zone_disp}, 12'h4FF);
      supply_low <= 1'b0;
      supply_high <= 1'b1;
      wt(6);
      chk({status_code, zone_disp}, 12'h5FF);
      supply_high <= 1'b0;
      response_in <= 8'h02;
      wt(6);
      chk({status_code, zone_disp}, 12'h3FF);
      chk({fault_out, fault_indicator}, 2'b10);
      repeat (24) begin
         @(posedge aclk);
         hi = hi | zone_indicator[1];
         lo = lo | ~zone_indicator[1];
      end
      chk({hi, lo}, 2'b11);
      response_in <= 8'h00;
      key_reset <= 1'b1;
      wt(6);
      chk({status_code, zone_disp}, 12'h000);
      chk(inhibit_out, 1'b1);
      key_reset <= 1'b0;
      remote_inhibit_n <= 1'b0;
      wt(6);
      chk({status_code, inhibit_out}, 5'h01);
      remote_inhibit_n <= 1'b1;
      key_test <= 1'b1;
      wt(6);
      chk({status_code, zone_disp}, 12'h101);
      select_button <= 1'b1;
      wt(2);
      select_button <= 1'b0;
      wt(6);
      chk(zone_disp, 8'h02);
      select_button <= 1'b1;
      accept_button <= 1'b1;
      wt(2);
      select_button <= 1'b0;
      accept_button <= 1'b0;
      wt(6);
      chk(status_code, 4'h8);
      key_test <= 1'b0;
      wt(6);
      chk(inhibit_out, 1'b0);
      clr;
      axi_wr(4'h0, 32'hB28, 2'h0);
      up_count <= 7'h02;
      wt(6);
      chk({logic_b, bus_out}, 9'h082);
      corrupt <= 1'b1;
      wt(6);
      chk({status_code, zone_disp}, 12'h7FF);
      corrupt <= 1'b0;
      fire_in <= 8'h01;
      wt(6);
      chk({logic_b, bus_out}, 9'h103);
      fire_in <= 8'h00;
      up_count <= 7'h00;
      clr;
      axi_wr(4'h0, 32'h108, 2'h0);
      fire_in <= 8'h20;
      wt(6);
      chk({zone_out, alarm_out}, 9'h041);
      chk({logic_a, logic_b}, 2'b01);
      chk({status_code, zone_disp}, 12'h606);
      remote_accept_n <= 1'b0;
      wt(6);
      chk({zone_out, alarm_out}, 9'h040);
      remote_accept_n <= 1'b1;
      fire_in <= 8'h00;
      wt(6);
      chk({zone_out, zone_indicator}, 16'h0020);
      fire_in <= 8'h01;
      wt(6);
      accept_button <= 1'b1;
      wt(2);
      accept_button <= 1'b0;
      wt(6);
      chk({zone_out, logic_a, alarm_out}, 10'h006);
      fire_in <= 8'h00;
      clr;
      chk({zone_indicator, status_code}, 12'h00F);
      vote(32'h108, 8'h08, 2'b11, 2'b10);
      vote(32'h108, 8'h10, 2'b11, 2'b01);
      vote(32'h1C8, 8'h11, 2'b11, 2'b00);
      vote(32'h1C8, 8'h09, 2'b11, 2'b10);
      vote(32'h1C8, 8'h90, 2'b11, 2'b01);
      vote(32'h328, 8'h81, 2'b01, 2'b00);
      vote(32'h328, 8'h85, 2'b01, 2'b01);
      vote(32'h728, 8'h3F, 2'b01, 2'b00);
      vote(32'h728, 8'h7F, 2'b01, 2'b01);
      clr;
      axi_wr(4'h0, 32'h118, 2'h0);
      fire_in <= 8'h01;
      wt(6);
      fire_in <= 8'h00;
      wt(6);
      chk(zone_out, 8'h01);
      remote_inhibit_n <= 1'b0;
      wt(6);
      remote_inhibit_n <= 1'b1;
      wt(6);
      chk({zone_out, zone_indicator}, 16'h0000);
      axi_wr(4'h0, 32'h2108, 2'h0);
      wt(100);
      chk({status_code, zone_disp, fault_indicator}, 13'h1FFF);
      axi_wr(4'h0, 32'h108, 2'h0);
      key_reset <= 1'b1;
      lamp_check_button <= 1'b1;
      wt(4);
      lamp_check_button <= 1'b0;
      wt(6);
      key_reset <= 1'b0;
      wt(6);
      chk(fault_indicator, 1'b0);
      tally_and_finish;
   end
endmodule // tb_fzv_top
